/* File: verilog/noec_pkg.sv */
// shared constants for the otp and ecc control block
package noec_pkg;
    localparam logic [7:0] CMD_WRDI = 8'h04;
    localparam logic [7:0] CMD_WREN = 8'h06;
    localparam logic [7:0] CMD_LOAD = 8'h02;
    localparam logic [7:0] CMD_EXEC = 8'h10;
    localparam logic [7:0] CMD_READ = 8'h13;
    localparam logic [7:0] CMD_GETF = 8'h0F;
    localparam logic [7:0] CMD_SETF = 8'h1F;
    localparam logic [7:0] FA_OTP = 8'hB0;
    localparam logic [7:0] FA_STAT = 8'hC0;
    // otp / config feature byte
    localparam int CFG_LOCK_POS = 7;
    localparam int CFG_OTP_EN_POS = 6;
    localparam int CFG_ECC_EN_POS = 4;
    localparam logic CFG_ECC_EN_RST = 1'b1;
    localparam logic CFG_OTP_EN_RST = 1'b0;
    localparam logic CFG_LOCK_RST = 1'b0;
    // status byte layout
    localparam int ST_OIP_POS = 0;
    localparam int ST_WEL_POS = 1;
    localparam int ST_EFAIL_POS = 2;
    localparam int ST_PFAIL_POS = 3;
    localparam int ST_ECC_LO_POS = 4;
    localparam int ST_ECC_HI_POS = 6;
    // page layout
    localparam logic [11:0] COL_MAIN_LAST = 12'h7FF;
    localparam logic [11:0] COL_SPARE_LAST = 12'h83F;
    localparam logic [11:0] COL_PAR_FIRST = 12'h840;
    localparam logic [11:0] COL_PAR_LAST = 12'h87F;
    localparam logic [11:0] COL_BBM = 12'h800;
    localparam logic [7:0] BBM_VALUE = 8'h00;
    localparam int PAGE_BYTES = 2176;
    localparam int BLK_PAGE_BITS = 6;
    // otp window
    localparam int OTP_PAGES = 4;
    localparam logic [15:0] OTP_FIRST_PAGE = 16'h0002;
    localparam logic [15:0] OTP_LAST_PAGE = 16'h0005;
    // ecc result
    localparam logic [3:0] ECC_CAP = 4'h8;
    localparam logic [3:0] ECC_LOW_HI = 4'h4;
    localparam logic [3:0] ECC_CLEAR = 4'h0;
    localparam logic [1:0] ECC_NONE = 2'b00;
    localparam logic [1:0] ECC_FIXED = 2'b01;
    localparam logic [1:0] ECC_FAIL = 2'b10;
    localparam logic [1:0] ECC_FULL = 2'b11;
endpackage

/* File: verilog/noec_ecc_result.sv */
// holds the ecc result field and encodes the corrected error count
`timescale 1ns/1ps
`default_nettype none
module noec_ecc_result
    import noec_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic load,
    input wire logic [3:0] err_count,
    output logic [3:0] field
);
    logic [3:0] next_field;

    always_comb
    begin
        next_field = {2'b00, ECC_NONE};
        if (err_count == 4'h0)
            next_field = {2'b00, ECC_NONE}; // RL1
        else if (err_count > ECC_CAP)
            next_field = {2'b00, ECC_FAIL}; // RL3
        else if (err_count == ECC_CAP)
            next_field = {2'b00, ECC_FULL}; // RL4
        else if (err_count <= ECC_LOW_HI)
            next_field = {2'b00, ECC_FIXED}; // RL2
        else
            next_field = {2'(err_count - ECC_LOW_HI), ECC_FIXED}; // RL2
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            field <= ECC_CLEAR;
        else if (clear)
            field <= ECC_CLEAR; // RL20
        else if (load)
            field <= next_field; // RL20
    end

    ecc_none_a: assert property (@(posedge clk) disable iff (!rst_n) // RL1
        load && !clear && err_count == 4'h0 |=> field[1:0] == 2'b00)
        else $error("zero errors not reported as none");
    ecc_count_a: assert property (@(posedge clk) disable iff (!rst_n) // RL2
        load && !clear && err_count == 4'h6 |=> field == 4'b1001)
        else $error("six errors misencoded");
    ecc_over_a: assert property (@(posedge clk) disable iff (!rst_n) // RL3
        load && !clear && err_count == 4'h9 |=> field[1:0] == 2'b10)
        else $error("uncorrectable page not flagged");
    ecc_full_a: assert property (@(posedge clk) disable iff (!rst_n) // RL4
        load && !clear && err_count == 4'h8 |=> field[1:0] == 2'b11)
        else $error("full capability not flagged");
endmodule
`default_nettype wire

/* File: verilog/noec_link_cap.sv */
// link clock side: latches a host command and hands it over by toggle
`timescale 1ns/1ps
`default_nettype none
module noec_link_cap
    import noec_pkg::*;
(
    input wire logic link_clk,
    input wire logic nrst,
    input wire logic cmd_strobe,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] feat_addr,
    input wire logic [7:0] feat_data,
    input wire logic [11:0] col_addr,
    input wire logic [15:0] page_addr,
    input wire logic ack_tog,
    output logic req_tog,
    output logic [7:0] h_code,
    output logic [7:0] h_faddr,
    output logic [7:0] h_fdata,
    output logic [11:0] h_col,
    output logic [15:0] h_page,
    output logic busy
);
    logic [1:0] rst_q;
    logic rst_n;
    logic [2:0] ack_s;
    logic ack_acc;

    always_ff @(posedge link_clk or negedge nrst)
    begin
        if (!nrst)
            rst_q <= 2'b00;
        else
            rst_q <= {rst_q[0], 1'b1};
    end
    assign rst_n = rst_q[1];

    // ack toggle from the control clock, three stages, settled on agreement
    always_ff @(posedge link_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_s <= 3'b000;
            ack_acc <= 1'b0;
        end
        else
        begin
            ack_s <= {ack_s[1:0], ack_tog};
            if (ack_s[1] == ack_s[2])
                ack_acc <= ack_s[2];
        end
    end

    // strobes that arrive while busy are dropped
    always_ff @(posedge link_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_tog <= 1'b0;
            busy <= 1'b0;
            h_code <= 8'h00;
            h_faddr <= 8'h00;
            h_fdata <= 8'h00;
            h_col <= 12'h000;
            h_page <= 16'h0000;
        end
        else if (cmd_strobe && !busy)
        begin
            req_tog <= !req_tog;
            busy <= 1'b1;
            h_code <= cmd_code;
            h_faddr <= feat_addr;
            h_fdata <= feat_data;
            h_col <= col_addr;
            h_page <= page_addr;
        end
        else if (busy && ack_acc == req_tog && ack_s[1] == ack_s[2] && ack_s[2] == req_tog)
            busy <= 1'b0;
    end
endmodule
`default_nettype wire

/* File: verilog/noec_ctrl.sv */
// otp window and on-chip ecc control, command side of a serial nand
//
// Operation
// (RL1) zero low result bits mean no errors; upper bits don't care
// (RL2) low bits 01: upper bits give 4-or-less, five, six or seven
// (RL3) errors beyond capability report 10, data left uncorrected
// (RL4) errors equal to capability are corrected, report 11
// (RL5) otp area is four good pages of 2176 bytes
// (RL6) lock bit is zero as shipped
// (RL7) host enables otp window by feature write at B0 first
// (RL8) host programs otp pages 02h to 05h in ascending order
// (RL9) load 02, execute 10 and read 13 work on otp pages
// (RL10) window bit routes program and read to otp or array
// (RL11) after lock commit the otp area is read only
// (RL12) host sets enable and lock, write enable, then execute
// (RL13) bad block keeps 00h at byte 2048 of first page
// (RL14) host treats non-FFh first spare byte as bad block
// (RL15) ecc is on after power up
// (RL16) program computes parity over cached page before array write
// (RL17) read corrects in cache and outputs only corrected data
// (RL18) writes to parity bytes 840 to 87F are ignored
// (RL19) main 000-7FF and spare 800-83F are ecc protected
// (RL20) result field cleared on reset and read start, set at end
// (RL21) status byte with result field is read at feature C0
// (RL22) programming a protected or locked area sets program fail
// (RL23) otp program outside allowed page range fails
`timescale 1ns/1ps
`default_nettype none
module noec_ctrl
    import noec_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic link_clk,
    input wire logic lk_cmd_strobe,
    input wire logic [7:0] lk_cmd_code,
    input wire logic [7:0] lk_feat_addr,
    input wire logic [7:0] lk_feat_data,
    input wire logic [11:0] lk_col_addr,
    input wire logic [15:0] lk_page_addr,
    input wire logic otp_lock_nv,
    input wire logic arr_done,
    input wire logic arr_fail,
    input wire logic [3:0] arr_err_count,
    input wire logic arr_bad_blk,
    output logic lk_busy,
    output logic [7:0] feat_rdata,
    output logic feat_rvalid,
    output logic [3:0] ecc_result_field,
    output logic p_fail,
    output logic wel,
    output logic oip,
    output logic otp_en,
    output logic otp_lock_bit,
    output logic ecc_en,
    output logic cache_we,
    output logic [11:0] cache_col,
    output logic [7:0] cache_wdata,
    output logic cache_prot,
    output logic arr_prog,
    output logic arr_read,
    output logic arr_otp,
    output logic [15:0] arr_page,
    output logic ecc_gen,
    output logic ecc_fix,
    output logic bbm_force
);
    typedef enum logic [1:0] {ST_IDLE, ST_ENC, ST_PROG, ST_READ} noec_state_e;

    function automatic logic in_col(input logic [11:0] a, input logic [11:0] lo,
                                    input logic [11:0] hi);
        in_col = (a >= lo) && (a <= hi);
    endfunction

    logic [1:0] rst_q;
    logic rst_n;
    logic req_tog;
    logic ack_tog;
    logic [2:0] req_s;
    logic req_acc;
    logic cmd_evt;
    logic [7:0] h_code;
    logic [7:0] h_faddr;
    logic [7:0] h_fdata;
    logic [11:0] h_col;
    logic [15:0] h_page;
    noec_state_e state;
    noec_state_e next_state;
    logic otp_locked;
    logic lock_loaded;
    logic [15:0] otp_next;
    logic is_exec;
    logic exec_lock;
    logic exec_bad;
    logic exec_ok;
    logic read_go;
    logic ecc_clear;
    logic ecc_load;

    ////////////////////////////////////////////////////////////////////////
    // reset release
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            rst_q <= 2'b00;
        else
            rst_q <= {rst_q[0], 1'b1};
    end
    assign rst_n = rst_q[1];

    ////////////////////////////////////////////////////////////////////////
    // link side and command crossing
    noec_link_cap u_link (
        .link_clk(link_clk),
        .nrst(nrst),
        .cmd_strobe(lk_cmd_strobe),
        .cmd_code(lk_cmd_code),
        .feat_addr(lk_feat_addr),
        .feat_data(lk_feat_data),
        .col_addr(lk_col_addr),
        .page_addr(lk_page_addr),
        .ack_tog(ack_tog),
        .req_tog(req_tog),
        .h_code(h_code),
        .h_faddr(h_faddr),
        .h_fdata(h_fdata),
        .h_col(h_col),
        .h_page(h_page),
        .busy(lk_busy)
    );

    // fields stay still until the ack returns, so they are read directly
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_s <= 3'b000;
            req_acc <= 1'b0;
            ack_tog <= 1'b0;
        end
        else
        begin
            req_s <= {req_s[1:0], req_tog};
            if (req_s[1] == req_s[2])
                req_acc <= req_s[2];
            ack_tog <= req_acc;
        end
    end
    assign cmd_evt = (req_s[1] == req_s[2]) && (req_s[2] != req_acc);

    ////////////////////////////////////////////////////////////////////////
    // command decode
    assign is_exec = cmd_evt && state == ST_IDLE && h_code == CMD_EXEC && wel;
    assign exec_lock = is_exec && otp_en && otp_lock_bit && !otp_locked; // RL12
    assign exec_bad = is_exec && otp_en && (otp_locked // RL11 RL22
        || h_page < OTP_FIRST_PAGE || h_page > OTP_LAST_PAGE // RL23 RL5
        || h_page != otp_next); // RL8
    assign exec_ok = is_exec && !exec_lock && !exec_bad; // RL9
    assign read_go = cmd_evt && state == ST_IDLE && h_code == CMD_READ; // RL9
    assign ecc_clear = read_go; // RL20
    assign ecc_load = state == ST_READ && arr_done && ecc_en;

    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (exec_ok)
                    next_state = ST_ENC;
                else if (read_go)
                    next_state = ST_READ;
            end
            ST_ENC:
                next_state = ST_PROG;
            ST_PROG, ST_READ:
            begin
                if (arr_done)
                    next_state = ST_IDLE;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            oip <= 1'b0;
        end
        else
        begin
            state <= next_state;
            oip <= next_state != ST_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // feature bits
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            otp_en <= CFG_OTP_EN_RST;
            ecc_en <= CFG_ECC_EN_RST; // RL15
            otp_lock_bit <= CFG_LOCK_RST; // RL6
        end
        else if (!lock_loaded)
            otp_lock_bit <= otp_lock_nv;
        else if (cmd_evt && h_code == CMD_SETF && h_faddr == FA_OTP)
        begin
            otp_en <= h_fdata[CFG_OTP_EN_POS]; // RL7 RL10
            ecc_en <= h_fdata[CFG_ECC_EN_POS];
            otp_lock_bit <= h_fdata[CFG_LOCK_POS] || otp_locked; // RL11
        end
    end

    // committed lock, caught from the nonvolatile copy after release
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            otp_locked <= CFG_LOCK_RST; // RL6
            lock_loaded <= 1'b0;
        end
        else if (!lock_loaded)
        begin
            otp_locked <= otp_lock_nv;
            lock_loaded <= 1'b1;
        end
        else if (exec_lock)
            otp_locked <= 1'b1; // RL12 RL11
    end

    // ascending otp page pointer
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            otp_next <= OTP_FIRST_PAGE;
        else if (exec_ok && otp_en)
            otp_next <= h_page + 16'h0001; // RL8
    end

    ////////////////////////////////////////////////////////////////////////
    // write enable latch and program fail
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            wel <= 1'b0;
        else if (cmd_evt && h_code == CMD_WREN)
            wel <= 1'b1;
        else if (is_exec || (cmd_evt && h_code == CMD_WRDI))
            wel <= 1'b0;
    end

    // set wins over the clear at execute start
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            p_fail <= 1'b0;
        else if (exec_bad || (state == ST_PROG && arr_done && arr_fail))
            p_fail <= 1'b1; // RL22 RL23
        else if (is_exec)
            p_fail <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // cache loads
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cache_we <= 1'b0;
            cache_col <= 12'h000;
            cache_wdata <= 8'h00;
            cache_prot <= 1'b0;
        end
        else
        begin
            cache_we <= cmd_evt && state == ST_IDLE && h_code == CMD_LOAD
                && !in_col(h_col, COL_PAR_FIRST, COL_PAR_LAST) // RL18
                && h_col < 12'(PAGE_BYTES); // RL5
            cache_col <= h_col;
            cache_wdata <= h_fdata;
            cache_prot <= in_col(h_col, 12'h000, COL_MAIN_LAST) // RL19
                || in_col(h_col, COL_BBM, COL_SPARE_LAST); // RL19
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // array and ecc strobes
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ecc_gen <= 1'b0;
            arr_prog <= 1'b0;
            arr_read <= 1'b0;
            arr_otp <= 1'b0;
            arr_page <= 16'h0000;
            ecc_fix <= 1'b0;
            bbm_force <= 1'b0;
        end
        else
        begin
            ecc_gen <= exec_ok && ecc_en; // RL16
            arr_prog <= state == ST_ENC; // RL16
            arr_read <= read_go;
            ecc_fix <= ecc_load; // RL17
            // factory mark 00h stands at the first spare byte
            bbm_force <= state == ST_READ && arr_done && arr_bad_blk // RL13 RL14
                && arr_page[BLK_PAGE_BITS-1:0] == '0 && !arr_otp;
            if (exec_ok || read_go)
            begin
                arr_otp <= otp_en; // RL10
                arr_page <= h_page;
            end
        end
    end

    noec_ecc_result u_ecc (
        .clk(ref_clk),
        .rst_n(rst_n),
        .clear(ecc_clear),
        .load(ecc_load),
        .err_count(arr_err_count),
        .field(ecc_result_field)
    );

    ////////////////////////////////////////////////////////////////////////
    // feature reads
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            feat_rdata <= 8'h00;
            feat_rvalid <= 1'b0;
        end
        else
        begin
            feat_rvalid <= cmd_evt && h_code == CMD_GETF;
            if (cmd_evt && h_code == CMD_GETF)
            begin
                feat_rdata <= 8'h00;
                if (h_faddr == FA_STAT)
                begin
                    feat_rdata[ST_ECC_HI_POS+:2] <= ecc_result_field[3:2]; // RL21
                    feat_rdata[ST_ECC_LO_POS+:2] <= ecc_result_field[1:0]; // RL21
                    feat_rdata[ST_PFAIL_POS] <= p_fail;
                    feat_rdata[ST_EFAIL_POS] <= 1'b0;
                    feat_rdata[ST_WEL_POS] <= wel;
                    feat_rdata[ST_OIP_POS] <= oip;
                end
                else if (h_faddr == FA_OTP)
                begin
                    feat_rdata[CFG_LOCK_POS] <= otp_lock_bit;
                    feat_rdata[CFG_OTP_EN_POS] <= otp_en;
                    feat_rdata[CFG_ECC_EN_POS] <= ecc_en;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    read_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL20
        read_go |=> ecc_result_field == 4'h0 && arr_read)
        else $error("read start did not clear result");
    lock_refuse_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL11
        is_exec && otp_en && otp_locked |=> p_fail ##1 !arr_prog ##1 !arr_prog)
        else $error("locked otp accepted a program");
    parity_skip_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL18
        cmd_evt && h_code == CMD_LOAD && h_col >= 12'h840 && h_col <= 12'h87F
        |=> !cache_we)
        else $error("parity byte write reached cache");
    otp_route_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL10
        exec_ok |-> ##2 arr_prog && arr_otp == $past(otp_en, 2))
        else $error("program routed to wrong area");
    parity_first_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL16
        arr_prog && $past(ecc_en, 2) |-> $past(ecc_gen))
        else $error("array write without parity step");
    ecc_powerup_a: assert property (@(posedge ref_clk) // RL15
        $rose(rst_n) |-> ecc_en)
        else $error("ecc off after reset");
    otp_range_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL23
        is_exec && otp_en && (h_page < 16'h0002 || h_page > 16'h0005)
        |=> p_fail && state == ST_IDLE)
        else $error("out of range otp page accepted");
    status_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL21
        cmd_evt && h_code == CMD_GETF && h_faddr == FA_STAT
        |=> feat_rvalid && feat_rdata[7:4] == $past(ecc_result_field))
        else $error("status byte lacks ecc result");
endmodule
`default_nettype wire

/* File: test/noec_host.sv */
// host model: issues one link command at a time and runs the link clock
`timescale 1ns/1ps
`default_nettype none
module noec_host
    import noec_pkg::*;
(
    output logic link_clk,
    input wire logic lk_busy,
    output logic lk_cmd_strobe,
    output logic [7:0] lk_cmd_code,
    output logic [7:0] lk_feat_addr,
    output logic [7:0] lk_feat_data,
    output logic [11:0] lk_col_addr,
    output logic [15:0] lk_page_addr
);
    logic run = 1'b1;
    initial
    begin
        {lk_cmd_strobe, lk_cmd_code, lk_feat_addr, lk_feat_data} = '0;
        {lk_col_addr, lk_page_addr} = '0;
        link_clk = 1'b0;
        forever #6 link_clk = run ? ~link_clk : 1'b0;
    end
    // clock stands still between commands
    task automatic send(input logic [7:0] c, input logic [7:0] fa, input logic [7:0] fd,
        input logic [11:0] col, input logic [15:0] pg);
        int n;
        run = 1'b1;
        repeat (2) @(negedge link_clk);
        {lk_cmd_code, lk_feat_addr, lk_feat_data, lk_col_addr, lk_page_addr} = {c, fa, fd, col, pg};
        lk_cmd_strobe = 1'b1;
        @(negedge link_clk);
        lk_cmd_strobe = 1'b0;
        n = 0;
        while (lk_busy !== 1'b1 && n < 20)
        begin
            @(negedge link_clk);
            n++;
        end
        n = 0;
        while (lk_busy !== 1'b0 && n < 100)
        begin
            @(negedge link_clk);
            n++;
        end
        // released data, column and page fields show the inverse, not the last value
        {lk_feat_data, lk_col_addr, lk_page_addr} = ~{fd, col, pg};
        run = 1'b0;
    endtask
    task automatic lock_otp(input logic [15:0] pg);
        send(CMD_SETF, FA_OTP, 8'hD0, 12'h000, 16'h0000);
        send(CMD_WREN, 8'h00, 8'h00, 12'h000, 16'h0000);
        send(CMD_EXEC, 8'h00, 8'h00, 12'h000, pg);
    endtask
endmodule
`default_nettype wire

/* File: test/nand_otp_and_ecc_control_tb.sv */
// testbench for the otp window and ecc control block
`timescale 1ns/1ps
`default_nettype none
module nand_otp_and_ecc_control_tb;
    import noec_pkg::*;
    logic ref_clk, nrst, link_clk, lk_cmd_strobe, lk_busy, arr_done, arr_bad_blk;
    logic [7:0] lk_cmd_code, lk_feat_addr, lk_feat_data, feat_rdata, cache_wdata;
    logic [11:0] lk_col_addr, cache_col;
    logic [15:0] lk_page_addr, arr_page;
    logic [3:0] arr_err_count, ecc_result_field, m, e;
    logic feat_rvalid, p_fail, wel, oip, otp_en, otp_lock_bit, ecc_en, cache_we, cache_prot;
    logic arr_prog, arr_read, arr_otp, ecc_gen, ecc_fix, bbm_force;
    logic s_gen, s_fix, s_we, s_prot, s_prog, s_otp, s_bbm;
    logic [11:0] cols [4] = '{12'h840, 12'h87F, 12'h000, 12'h83F};
    int fail_count = 0;
    int compares = 0;
    noec_host host (.link_clk(link_clk), .lk_busy(lk_busy), .lk_cmd_strobe(lk_cmd_strobe),
        .lk_cmd_code(lk_cmd_code), .lk_feat_addr(lk_feat_addr), .lk_feat_data(lk_feat_data),
        .lk_col_addr(lk_col_addr), .lk_page_addr(lk_page_addr));
    noec_ctrl uut (.ref_clk(ref_clk), .nrst(nrst), .link_clk(link_clk),
        .lk_cmd_strobe(lk_cmd_strobe), .lk_cmd_code(lk_cmd_code), .lk_feat_addr(lk_feat_addr),
        .lk_feat_data(lk_feat_data), .lk_col_addr(lk_col_addr), .lk_page_addr(lk_page_addr),
        .otp_lock_nv(1'b0), .arr_done(arr_done), .arr_fail(1'b0), .arr_err_count(arr_err_count),
        .arr_bad_blk(arr_bad_blk), .lk_busy(lk_busy), .feat_rdata(feat_rdata),
        .feat_rvalid(feat_rvalid), .ecc_result_field(ecc_result_field), .p_fail(p_fail),
        .wel(wel), .oip(oip), .otp_en(otp_en), .otp_lock_bit(otp_lock_bit), .ecc_en(ecc_en),
        .cache_we(cache_we), .cache_col(cache_col), .cache_wdata(cache_wdata),
        .cache_prot(cache_prot), .arr_prog(arr_prog), .arr_read(arr_read), .arr_otp(arr_otp),
        .arr_page(arr_page), .ecc_gen(ecc_gen), .ecc_fix(ecc_fix), .bbm_force(bbm_force));
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // sticky records of the one-cycle pulses
    always @(posedge ref_clk)
    begin
        if (ecc_gen === 1'b1) s_gen <= 1'b1;
        if (ecc_fix === 1'b1) s_fix <= 1'b1;
        if (cache_we === 1'b1) s_we <= 1'b1;
        if (cache_we === 1'b1 && cache_prot === 1'b1) s_prot <= 1'b1;
        if (arr_prog === 1'b1) s_prog <= 1'b1;
        if ((arr_prog === 1'b1 || arr_read === 1'b1) && arr_otp === 1'b1) s_otp <= 1'b1;
        if (bbm_force === 1'b1) s_bbm <= 1'b1;
    end
    // array answers three cycles after each program or read
    initial
    begin
        arr_done = 1'b0;
        forever
        begin
            @(posedge ref_clk iff (arr_prog === 1'b1 || arr_read === 1'b1));
            repeat (3) @(negedge ref_clk);
            arr_done = 1'b1;
            @(negedge ref_clk);
            arr_done = 1'b0;
        end
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] c, input logic [7:0] fa, input logic [7:0] fd,
        input logic [11:0] col, input logic [15:0] pg);
        int n;
        {s_gen, s_fix, s_we, s_prot, s_prog, s_otp, s_bbm} = '0;
        host.send(c, fa, fd, col, pg);
        n = 0;
        while (oip !== 1'b0 && n < 100)
        begin
            @(negedge ref_clk);
            n++;
        end
        repeat (3) @(negedge ref_clk);
    endtask
    task automatic prog(input logic [15:0] pg);
        cmd(CMD_WREN, 8'h00, 8'h00, 12'h000, 16'h0000);
        cmd(CMD_EXEC, 8'h00, 8'h00, 12'h000, pg);
    endtask
    function automatic logic [3:0] exp_ecc(input int n);
        return n == 0 ? 4'h0 : n <= 4 ? 4'h1 : n <= 7 ? {n[1:0], 2'b01} :
            n == 8 ? 4'h3 : 4'h2;
    endfunction
    initial
    begin
        #100000;
        fail_count++;
        results();
    end
    initial
    begin
        nrst = 1'b0;
        arr_err_count = 4'h0;
        arr_bad_blk = 1'b0;
        repeat (16) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (20) @(negedge ref_clk);
        chk("ecc_en", ecc_en, 8'h01);
        chk("otp_lock_bit", otp_lock_bit, 8'h00);
        chk("ecc_result_field", ecc_result_field, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 10; i++)
        begin
            arr_err_count = i[3:0];
            e = exp_ecc(i);
            m = (e[1:0] == ECC_FIXED) ? 4'hF : 4'h3;
            cmd(CMD_READ, 8'h00, 8'h00, 12'h000, 16'h0001);
            chk("ecc_fix", s_fix, 8'h01);
            chk("ecc_result_field", ecc_result_field & m, e & m);
            cmd(CMD_GETF, FA_STAT, 8'h00, 12'h000, 16'h0000);
            chk("feat_rdata", feat_rdata[7:4] & m, e & m);
        end
        $display("test ecc result done");
        for (int j = 0; j < 4; j++)
        begin
            cmd(CMD_LOAD, 8'h00, 8'hA5, cols[j], 16'h0000);
            chk("cache_we", s_we, 8'(j >= 2));
            chk("cache_prot", s_prot, 8'(j >= 2));
            chk("cache_wdata", cache_wdata, 8'hA5);
        end
        $display("test cache columns done");
        prog(16'h0040);
        chk("ecc_gen", s_gen, 8'h01);
        chk("arr_prog", s_prog, 8'h01);
        chk("arr_otp", s_otp, 8'h00);
        cmd(CMD_SETF, FA_OTP, 8'h50, 12'h000, 16'h0000);
        chk("otp_en", otp_en, 8'h01);
        prog(OTP_FIRST_PAGE);
        chk("arr_otp", s_otp, 8'h01);
        chk("p_fail", p_fail, 8'h00);
        prog(16'h0006);
        chk("p_fail", p_fail, 8'h01);
        prog(16'h0003);
        chk("p_fail", p_fail, 8'h00);
        prog(16'h0003);
        chk("p_fail", p_fail, 8'h01);
        cmd(CMD_READ, 8'h00, 8'h00, 12'h000, 16'h0003);
        chk("arr_otp", s_otp, 8'h01);
        $display("test otp access done");
        {s_gen, s_fix, s_we, s_prot, s_prog, s_otp, s_bbm} = '0;
        host.lock_otp(16'h0004);
        repeat (10) @(negedge ref_clk);
        chk("otp_lock_bit", otp_lock_bit, 8'h01);
        chk("arr_prog", s_prog, 8'h00);
        prog(16'h0003);
        chk("p_fail", p_fail, 8'h01);
        chk("arr_prog", s_prog, 8'h00);
        cmd(CMD_SETF, FA_OTP, 8'h10, 12'h000, 16'h0000);
        chk("otp_lock_bit", otp_lock_bit, 8'h01);
        $display("test otp lock done");
        arr_bad_blk = 1'b1;
        arr_err_count = 4'h0;
        cmd(CMD_READ, 8'h00, 8'h00, 12'h000, 16'h0040);
        chk("bbm_force", s_bbm, 8'h01);
        cmd(CMD_READ, 8'h00, 8'h00, 12'h000, 16'h0041);
        chk("bbm_force", s_bbm, 8'h00);
        $display("test bad block done");
        results();
    end
endmodule
`default_nettype wire
